/* File: src/jlp_map.vh */
`ifndef JLP_MAP_VH
`define JLP_MAP_VH

// ----------------------------------------------------------------------------
// register offsets (12-bit register address space)
// ----------------------------------------------------------------------------
`define JLP_ADDR_W              12
`define JLP_LANE7_RX_IDENT      12'h442
`define JLP_LANE7_RX_CHECKSUM   12'h445
`define JLP_LANE7_CALC_CHECKSUM 12'h446
`define JLP_LINK_DEVICE_IDENT   12'h450
`define JLP_LINK_BANK_IDENT     12'h451
`define JLP_LANE0_IDENT_ADJUST  12'h452
`define JLP_DESCRAMBLE_LANES    12'h453
`define JLP_OCTETS_PER_FRAME    12'h454
`define JLP_FRAMES_PER_MF       12'h455
`define JLP_CONVERTERS_PER_DEV  12'h456
`define JLP_CTRL_BITS_RES       12'h457

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define JLP_IDENT_MSB           4
`define JLP_K_MSB               4
`define JLP_ADJDIR_BIT          6
`define JLP_PHADJ_BIT           5
`define JLP_DESCRAMBLE_BIT      7
`define JLP_CS_MSB              7
`define JLP_CS_LSB              6

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define JLP_RST_BYTE            8'h00
`define JLP_RST_FIELD5          5'h00
`define JLP_RST_DESCRAMBLE      1'h1
`define JLP_RST_K_MINUS1        5'h1F
`define JLP_K16_MINUS1          5'h0F
`define JLP_RST_LANES_MINUS1    5'h07
`define JLP_RST_OCTETS_MINUS1   8'h00
`define JLP_RST_CONV_MINUS1     8'h01
`define JLP_RST_CTRL_BITS       2'h0
`define JLP_RST_RES_MINUS1      5'h0F

// ----------------------------------------------------------------------------
// lane 7 initial alignment configuration octet indices
// ----------------------------------------------------------------------------
`define JLP_ILAS_IDX_W          4
`define JLP_ILAS_IDX_FIRST      4'h0
`define JLP_ILAS_IDX_LID        4'h2
`define JLP_ILAS_IDX_CHECKSUM   4'hD

`endif

/* File: src/jlp_link_param_regs.v */
// Functional notes
// - capture lane 7 lane ID, 5 bits
// - store received lane 7 checksum, read-only
// - compute own lane 7 checksum, read-only
// - bank ID writable, resets to zero
// - adjust direction bit 6, phase bit 5
// - lane 0 ID writable, resets zero
// - bit 7 enables descrambling, on after reset
// - lane count minus one, read-only
// - octets per frame minus one, informational
// - K minus one, reset 0x1F
// - converters minus one, reset 0x1
// - control bits per sample always zero
// - resolution minus one reads 0x0F

`include "jlp_map.vh"

module jlp_link_param_regs (
  input  wire        core_clk,           // register clock, 20 MHz
  input  wire        rst_b,              // asynchronous reset, active low
  input  wire [11:0] reg_addr,           // register address
  input  wire        reg_wr_en,          // write strobe, one cycle
  input  wire [7:0]  reg_wr_data,        // write data
  input  wire        reg_rd_en,          // read strobe, one cycle
  output wire [7:0]  reg_rd_data,        // read data, valid with reg_rd_valid
  output wire        reg_rd_valid,       // read answer pulse
  input  wire        link_soft_reset,    // link_receive_core held in soft reset
  input  wire        ilas_octet_valid,   // lane 7 configuration octet strobe
  input  wire [3:0]  ilas_octet_idx,     // octet index 0..13 in the config
  input  wire [7:0]  ilas_octet,         // received configuration octet
  output wire [7:0]  cfg_device_ident,   // expected device id
  output wire [7:0]  cfg_bank_ident,     // expected bank id
  output wire [4:0]  cfg_lane0_ident,    // expected lane 0 id
  output wire        cfg_lmfc_adj_dir,   // lmfc adjust direction
  output wire        cfg_phase_adj_req,  // phase adjust request
  output wire        cfg_descramble_en,  // receive descrambling enable
  output wire [4:0]  cfg_k_minus1,       // frames per multiframe minus one
  output wire        lane7_checksum_ok,  // calculated equals received checksum
  output wire        lane7_cfg_done      // lane 7 config fully captured
);

  // --------------------------------------------------------------------------
  // writable configuration
  // --------------------------------------------------------------------------
  reg [7:0] device_ident_reg;
  reg [7:0] bank_ident_reg;
  reg [4:0] lane0_ident_reg;
  reg       adj_dir_reg;
  reg       phase_adj_reg;
  reg       descramble_reg;
  reg [4:0] k_minus1_reg;

  // --------------------------------------------------------------------------
  // write decode
  // --------------------------------------------------------------------------
  // decode is exact over all twelve address bits, so aliases never hit
  wire wr_dev  = reg_wr_en && (reg_addr == `JLP_LINK_DEVICE_IDENT);
  wire wr_bank = reg_wr_en && (reg_addr == `JLP_LINK_BANK_IDENT);
  wire wr_lid0 = reg_wr_en && (reg_addr == `JLP_LANE0_IDENT_ADJUST);
  wire wr_scr  = reg_wr_en && (reg_addr == `JLP_DESCRAMBLE_LANES);
  wire wr_k    = reg_wr_en && (reg_addr == `JLP_FRAMES_PER_MF);

  // --------------------------------------------------------------------------
  // device and bank identification
  // --------------------------------------------------------------------------
  // writes are accepted in any state; keeping them inside the soft reset
  // window is left to software, since the core may be held in reset remotely
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      device_ident_reg <= `JLP_RST_BYTE;
    end else if (wr_dev) begin
      device_ident_reg <= reg_wr_data;
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      bank_ident_reg <= `JLP_RST_BYTE;
    end else if (wr_bank) begin
      bank_ident_reg <= reg_wr_data;
    end
  end

  // --------------------------------------------------------------------------
  // lane 0 identification and subclass 2 adjust
  // --------------------------------------------------------------------------
  // bit 7 is reserved and never stored
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lane0_ident_reg <= `JLP_RST_FIELD5;
    end else if (wr_lid0) begin
      lane0_ident_reg <= reg_wr_data[`JLP_IDENT_MSB:0];
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      adj_dir_reg <= 1'h0;
    end else if (wr_lid0) begin
      adj_dir_reg <= reg_wr_data[`JLP_ADJDIR_BIT];
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_adj_reg <= 1'h0;
    end else if (wr_lid0) begin
      phase_adj_reg <= reg_wr_data[`JLP_PHADJ_BIT];
    end
  end

  // --------------------------------------------------------------------------
  // descrambling and multiframe length
  // --------------------------------------------------------------------------
  // reset leaves descrambling on until software clears it
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      descramble_reg <= `JLP_RST_DESCRAMBLE;
    end else if (wr_scr) begin
      descramble_reg <= reg_wr_data[`JLP_DESCRAMBLE_BIT];
    end
  end

  // only bits 4:0 are stored, bits 7:5 are reserved
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      k_minus1_reg <= `JLP_RST_K_MINUS1;
    end else if (wr_k) begin
      k_minus1_reg <= reg_wr_data[`JLP_K_MSB:0];
    end
  end

  // --------------------------------------------------------------------------
  // lane 7 configuration capture and checksum
  // --------------------------------------------------------------------------
  reg [4:0] rx_lane7_ident_reg;
  reg [7:0] rx_lane7_checksum_reg;
  reg [7:0] calc_lane7_checksum_reg;
  reg [7:0] sum_reg;
  reg [7:0] sum_next;
  reg       cfg_done_reg;
  reg       chk_ok_reg;

  // --------------------------------------------------------------------------
  // octet index decode
  // --------------------------------------------------------------------------
  // indices 14 and 15 match nothing and are dropped
  wire idx_first = (ilas_octet_idx == `JLP_ILAS_IDX_FIRST);
  wire idx_lid   = (ilas_octet_idx == `JLP_ILAS_IDX_LID);
  wire idx_chk   = (ilas_octet_idx == `JLP_ILAS_IDX_CHECKSUM);
  wire idx_data  = (ilas_octet_idx < `JLP_ILAS_IDX_CHECKSUM);

  // --------------------------------------------------------------------------
  // running octet sum
  // --------------------------------------------------------------------------
  // running modulo-256 octet sum; the first octet restarts it so that a
  // repeated alignment sequence never accumulates over a stale total
  always @* begin
    sum_next = sum_reg;
    if (ilas_octet_valid && idx_data) begin
      if (idx_first) begin
        sum_next = ilas_octet;
      end else begin
        sum_next = sum_reg + ilas_octet;
      end
    end
  end

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sum_reg <= `JLP_RST_BYTE;
    end else begin
      sum_reg <= sum_next;
    end
  end

  // --------------------------------------------------------------------------
  // lane 7 identification capture
  // --------------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_lane7_ident_reg <= `JLP_RST_FIELD5;
    end else if (ilas_octet_valid && idx_lid) begin
      rx_lane7_ident_reg <= ilas_octet[`JLP_IDENT_MSB:0];
    end
  end

  // --------------------------------------------------------------------------
  // lane 7 checksum capture
  // --------------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_lane7_checksum_reg <= `JLP_RST_BYTE;
    end else if (ilas_octet_valid && idx_chk) begin
      rx_lane7_checksum_reg <= ilas_octet;
    end
  end

  // the checksum octet itself is left out of the sum
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      calc_lane7_checksum_reg <= `JLP_RST_BYTE;
    end else if (ilas_octet_valid && idx_chk) begin
      calc_lane7_checksum_reg <= sum_reg;
    end
  end

  // compared with the live octet so the flag lands with the capture
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      chk_ok_reg <= 1'h0;
    end else if (ilas_octet_valid && idx_chk) begin
      chk_ok_reg <= (sum_reg == ilas_octet);
    end
  end

  // a new sequence withdraws the previous result at its first octet
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cfg_done_reg <= 1'h0;
    end else if (ilas_octet_valid && idx_chk) begin
      cfg_done_reg <= 1'h1;
    end else if (ilas_octet_valid && idx_first) begin
      cfg_done_reg <= 1'h0;
    end
  end

  // --------------------------------------------------------------------------
  // read path
  // --------------------------------------------------------------------------
  reg [7:0] rd_data_reg;
  reg [7:0] rd_data_next;
  reg       rd_valid_reg;

  // reserved bits are never stored, so they read back as zero
  always @* begin
    rd_data_next = 8'h00;
    case (reg_addr)
      `JLP_LANE7_RX_IDENT: begin
        rd_data_next = {3'h0, rx_lane7_ident_reg};
      end
      `JLP_LANE7_RX_CHECKSUM: begin
        rd_data_next = rx_lane7_checksum_reg;
      end
      `JLP_LANE7_CALC_CHECKSUM: begin
        rd_data_next = calc_lane7_checksum_reg;
      end
      `JLP_LINK_DEVICE_IDENT: begin
        rd_data_next = device_ident_reg;
      end
      `JLP_LINK_BANK_IDENT: begin
        rd_data_next = bank_ident_reg;
      end
      `JLP_LANE0_IDENT_ADJUST: begin
        rd_data_next = {1'h0, adj_dir_reg, phase_adj_reg, lane0_ident_reg};
      end
      `JLP_DESCRAMBLE_LANES: begin
        rd_data_next = {descramble_reg, 2'h0, `JLP_RST_LANES_MINUS1};
      end
      `JLP_OCTETS_PER_FRAME: begin
        rd_data_next = `JLP_RST_OCTETS_MINUS1;
      end
      `JLP_FRAMES_PER_MF: begin
        rd_data_next = {3'h0, k_minus1_reg};
      end
      `JLP_CONVERTERS_PER_DEV: begin
        rd_data_next = `JLP_RST_CONV_MINUS1;
      end
      `JLP_CTRL_BITS_RES: begin
        rd_data_next = {`JLP_RST_CTRL_BITS, 1'h0, `JLP_RST_RES_MINUS1};
      end
      default: begin
        rd_data_next = 8'h00;
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // read answer
  // --------------------------------------------------------------------------
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_valid_reg <= 1'h0;
    end else begin
      rd_valid_reg <= reg_rd_en;
    end
  end

  // data holds between reads, so software may sample it late
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_reg <= 8'h00;
    end else if (reg_rd_en) begin
      rd_data_reg <= rd_data_next;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign reg_rd_data       = rd_data_reg;
  assign reg_rd_valid      = rd_valid_reg;
  assign cfg_device_ident  = device_ident_reg;
  assign cfg_bank_ident    = bank_ident_reg;
  assign cfg_lane0_ident   = lane0_ident_reg;
  assign cfg_lmfc_adj_dir  = adj_dir_reg;
  assign cfg_phase_adj_req = phase_adj_reg;
  assign cfg_descramble_en = descramble_reg;
  assign cfg_k_minus1      = k_minus1_reg;
  assign lane7_checksum_ok = chk_ok_reg;
  assign lane7_cfg_done    = cfg_done_reg;

endmodule // jlp_link_param_regs

/* File: verif/jlp_link_param_regs_props.sv */
module jlp_link_param_regs_props (
  input wire        core_clk,          // clock
  input wire        rst_b,             // reset, active low
  input wire [11:0] reg_addr,          // address
  input wire        reg_wr_en,         // write strobe
  input wire [7:0]  reg_wr_data,       // write data
  input wire        reg_rd_en,         // read strobe
  input wire [7:0]  reg_rd_data,       // read data
  input wire        reg_rd_valid,      // read answer
  input wire        link_soft_reset,   // core held in soft reset
  input wire        ilas_octet_valid,  // octet strobe
  input wire [3:0]  ilas_octet_idx,    // octet index
  input wire [7:0]  cfg_device_ident,  // device id
  input wire [7:0]  cfg_bank_ident,    // bank id
  input wire [4:0]  cfg_lane0_ident,   // lane 0 id
  input wire        cfg_lmfc_adj_dir,  // adjust direction
  input wire        cfg_phase_adj_req, // phase request
  input wire        cfg_descramble_en, // descramble enable
  input wire [4:0]  cfg_k_minus1,      // frames minus one
  input wire        lane7_cfg_done     // capture done
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_bank; reg_wr_en && reg_addr == 12'h451 |=> cfg_bank_ident == $past(reg_wr_data);
  endproperty
  a_bank: assert property (p_bank) else $error("bank id not written");
  property p_lid; reg_wr_en && reg_addr == 12'h452 |=>
    cfg_lane0_ident == $past(reg_wr_data[4:0]) && cfg_lmfc_adj_dir == $past(reg_wr_data[6]);
  endproperty
  a_lid: assert property (p_lid) else $error("lane 0 field wrong");
  property p_scr; reg_wr_en && reg_addr == 12'h453 |=> cfg_descramble_en == $past(reg_wr_data[7]);
  endproperty
  a_scr: assert property (p_scr) else $error("descramble bit wrong");
  property p_k; reg_wr_en && reg_addr == 12'h455 |=> cfg_k_minus1 == $past(reg_wr_data[4:0]);
  endproperty
  a_k: assert property (p_k) else $error("k field wrong");
  property p_res; reg_rd_en && reg_addr == 12'h457 |=> reg_rd_valid && reg_rd_data == 8'h0F;
  endproperty
  a_res: assert property (p_res) else $error("resolution read wrong");
  property p_conv; reg_rd_en && reg_addr == 12'h456 |=> reg_rd_data == 8'h01; endproperty
  a_conv: assert property (p_conv) else $error("converter read wrong");
  property p_rsvd; reg_rd_en && reg_addr == 12'h455 |=> reg_rd_data[7:5] == 3'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_done; ilas_octet_valid && ilas_octet_idx == 4'hD |=> lane7_cfg_done; endproperty
  a_done: assert property (p_done) else $error("capture not done");
  property p_frozen; !link_soft_reset |-> $stable(cfg_device_ident) && $stable(cfg_bank_ident)
    && $stable(cfg_lane0_ident) && $stable(cfg_lmfc_adj_dir) && $stable(cfg_phase_adj_req)
    && $stable(cfg_descramble_en) && $stable(cfg_k_minus1);
  endproperty
  a_frozen: assert property (p_frozen) else $error("config moved outside soft reset");
  c_k: cover property (reg_wr_en && reg_addr == 12'h455);
  c_rd: cover property (reg_rd_en && reg_addr == 12'h457);
  c_sum: cover property (ilas_octet_valid && ilas_octet_idx == 4'hD);
endmodule // jlp_link_param_regs_props

bind jlp_link_param_regs jlp_link_param_regs_props u_props (.*);

/* File: verif/jlp_tx_model.sv */
module jlp_tx_model (
  input  wire       core_clk,         // clock
  output reg        ilas_octet_valid, // octet strobe
  output reg  [3:0] ilas_octet_idx,   // octet index
  output reg  [7:0] ilas_octet        // octet value
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ilas_octet_valid = 1'b0;
    ilas_octet_idx = 4'h0;
    ilas_octet = 8'h00;
  end
  // idle octet line toggles so a stale value never looks like a capture
  task automatic send(input logic [7:0] oct [14], input int gap);
    for (int i = 0; i < 14; i++) begin
      @(negedge core_clk);
      ilas_octet_valid = 1'b1;
      ilas_octet_idx = i[3:0];
      ilas_octet = oct[i];
      repeat (gap) begin
        @(negedge core_clk);
        ilas_octet_valid = 1'b0;
        ilas_octet = ~ilas_octet;
      end
    end
    @(negedge core_clk);
    ilas_octet_valid = 1'b0;
    ilas_octet = ~ilas_octet;
  endtask
endmodule // jlp_tx_model

/* File: verif/jlp_link_param_regs_tb_top.sv */
module jlp_link_param_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic        reg_wr_en = 1'b0;
  logic [7:0]  reg_wr_data = 8'h00;
  logic        reg_rd_en = 1'b0;
  logic        link_soft_reset = 1'b1;
  wire  [7:0]  reg_rd_data, cfg_device_ident, cfg_bank_ident, ilas_octet;
  wire  [4:0]  cfg_lane0_ident, cfg_k_minus1;
  wire  [3:0]  ilas_octet_idx;
  wire         reg_rd_valid, cfg_lmfc_adj_dir, cfg_phase_adj_req, cfg_descramble_en;
  wire         lane7_checksum_ok, lane7_cfg_done, ilas_octet_valid;
  int          failures = 0;
  int          n_tests = 0;
  int          k;
  logic [7:0]  cfg_sum, exp_sum;
  logic [7:0]  mdl [int];
  logic [7:0]  msk [int];
  logic [7:0]  oct [14];
  logic [11:0] adr [12] = '{12'h442, 12'h445, 12'h446, 12'h450, 12'h451, 12'h452,
                            12'h453, 12'h454, 12'h455, 12'h456, 12'h457, 12'h447};
  logic [7:0]  rv [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
                           8'h87, 8'h00, 8'h1F, 8'h01, 8'h0F, 8'h00};
  logic [7:0]  wm [12] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h7F,
                           8'h80, 8'h00, 8'h1F, 8'h00, 8'h00, 8'h00};
  jlp_link_param_regs dut (.*);
  jlp_tx_model tx (.*);
  always #25 core_clk = ~core_clk;
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge core_clk);
    reg_wr_en = 1'b0;
    mdl[a] = (mdl[a] & ~msk[a]) | (d & msk[a]);
  endtask
  task rd(input logic [11:0] a);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge core_clk);
    reg_rd_en = 1'b0;
    chk("rd_valid", 8'h01, {7'h00, reg_rd_valid});
    chk($sformatf("rd %h", a), mdl[a], reg_rd_data);
  endtask
  task chk_cfg;
    chk("dev", mdl[12'h450], cfg_device_ident);
    chk("bank", mdl[12'h451], cfg_bank_ident);
    chk("lid0", {3'h0, mdl[12'h452][4:0]}, {3'h0, cfg_lane0_ident});
    chk("adj", {6'h00, mdl[12'h452][6:5]}, {6'h00, cfg_lmfc_adj_dir, cfg_phase_adj_req});
    chk("scr", {7'h00, mdl[12'h453][7]}, {7'h00, cfg_descramble_en});
    chk("k", {3'h0, mdl[12'h455][4:0]}, {3'h0, cfg_k_minus1});
  endtask
  task frame(input bit bad, input int gap);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 13; i++) begin
      oct[i] = 8'($urandom);
      s += oct[i];
    end
    oct[13] = bad ? ~s : s;
    tx.send(oct, gap);
    mdl[12'h442] = {3'h0, oct[2][4:0]};
    mdl[12'h445] = oct[13];
    mdl[12'h446] = s;
    chk("sum_ok", {7'h00, !bad}, {7'h00, lane7_checksum_ok});
    chk("done", 8'h01, {7'h00, lane7_cfg_done});
    rd(12'h442);
    rd(12'h445);
    rd(12'h446);
  endtask
  task stop_test;
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    #(50 * 5000);
    failures++;
    stop_test;
  end
  initial begin
    void'($urandom(32'h93b3cce8));
    foreach (adr[i]) begin
      mdl[adr[i]] = rv[i];
      msk[adr[i]] = wm[i];
    end
    repeat (10) @(negedge core_clk);
    rst_b = 1'b1;
    chk_cfg;
    foreach (adr[i]) rd(adr[i]);
    wr(12'h455, 8'hEF);
    wr(12'h453, 8'h7F);
    rd(12'h455);
    rd(12'h453);
    chk_cfg;
    // software keeps the core in soft reset while the fields change
    repeat (24) begin
      k = $urandom % 12;
      wr(adr[k], 8'($urandom));
      rd(adr[k]);
      chk_cfg;
    end
    cfg_sum = 8'h00;
    exp_sum = 8'h00;
    for (int a = 12'h450; a <= 12'h457; a++) begin
      rd(a[11:0]);
      cfg_sum += reg_rd_data;
      exp_sum += mdl[a];
    end
    chk("cfg_sum", exp_sum, cfg_sum);
    link_soft_reset = 1'b0;
    frame(1'b0, 0);
    frame(1'b0, 2);
    frame(1'b1, 0);
    stop_test;
  end
endmodule // jlp_link_param_regs_tb_top
